/* File: design/swbt_core.v */
// write burst timing: latency, burst length, recovery and turnaround
// Operation
// R1 - controller spaces write to precharge by latency, burst share, recovery
// R2 - controller also honours row active minimum time before precharge
// R3 - first data beat lands additive plus column write latency after write
// R4 - recovery counts from first edge after last beat, gates precharge
// R5 - mode 00 gives eight beats; 01 lets burst select bit choose
// R6 - mode 10 forces chopped four beats whatever the select bit says
// R7 - same group read waits long write to read time after last beat
// R8 - other group read waits short write to read time after last beat
// R9 - inversion enabled uses the longer inverted write recovery time
// R10 - two clock preamble forbids the lowest column write latency of nine
// R11 - checksum adds two beats after data; spacing covers longer burst
// R12 - data lines outside burst beats are ignored as do not care
`timescale 1ns/1ps
`include "swbt_regs.vh"
module swbt_core #(
   parameter DW = 16,
   parameter LATW = 6,
   parameter TW = 8
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_ck,
   input wire i_wr_cmd,
   input wire i_burst_select_address_bit,
   input wire i_bank_group,
   input wire [DW-1:0] i_dq,
   input wire [1:0] i_burst_mode,
   input wire [LATW-1:0] i_additive_latency,
   input wire [LATW-1:0] i_column_write_latency,
   input wire i_data_bus_inversion,
   input wire i_write_crc,
   input wire i_preamble_2ck,
   input wire [TW-1:0] i_write_recovery_time,
   input wire [TW-1:0] i_write_recovery_inverted,
   input wire [TW-1:0] i_write_to_read_long,
   input wire [TW-1:0] i_write_to_read_short,
   output wire o_beat_valid,
   input wire i_beat_ready,
   output wire [DW-1:0] o_beat_data,
   output reg o_beat_crc,
   output reg o_burst_active,
   output reg o_precharge_ok,
   output reg o_read_same_ok,
   output reg o_read_other_ok,
   output reg o_latency_error,
   output wire o_overflow
);
   // ---------------------------------------------------------------
   // link clock sampling and edge detection
   // ---------------------------------------------------------------
   reg [2:0] ck_q;
   reg [DW-1:0] dq_s1_q;
   reg [DW-1:0] dq_s2_q;
   reg [2:0] cmd_s_q;
   reg [1:0] bsel_s_q;
   reg [1:0] bg_s_q;
   wire ck_rise;
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         ck_q <= 3'h0;
         cmd_s_q <= 3'h0;
         bsel_s_q <= 2'h0;
         bg_s_q <= 2'h0;
         dq_s1_q <= {DW{1'b0}};
         dq_s2_q <= {DW{1'b0}};
      end else begin
         ck_q <= {ck_q[1:0], i_ck};
         cmd_s_q <= {cmd_s_q[1:0], i_wr_cmd};
         bsel_s_q <= {bsel_s_q[0], i_burst_select_address_bit};
         bg_s_q <= {bg_s_q[0], i_bank_group};
         dq_s1_q <= i_dq;
         dq_s2_q <= dq_s1_q;
      end
   end
   // stage 2 and later only; beats are sampled one per link edge
   assign ck_rise = ck_q[1] & ~ck_q[2];
   // ---------------------------------------------------------------
   // burst length decode
   // ---------------------------------------------------------------
   function [3:0] beats_for;
      input [1:0] mode;
      input bsel;
      begin
         case (mode)
            `SWBT_BM_FIXED8: beats_for = `SWBT_BEATS8; // [R5]
            `SWBT_BM_PERCMD: beats_for = bsel ? `SWBT_BEATS8 :
               `SWBT_BEATS4; // [R5]
            `SWBT_BM_FIXED4: beats_for = `SWBT_BEATS4; // [R6]
            default: beats_for = `SWBT_BEATS8;
         endcase
      end
   endfunction
   // ---------------------------------------------------------------
   // write sequencer
   // ---------------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_DATA = 2'h2;
   reg [1:0] st_q;
   reg [LATW:0] lat_q;
   reg [3:0] beat_q;
   reg [3:0] last_q;
   reg bg_q;
   reg fin_q;
   wire [LATW:0] wr_lat;
   wire [3:0] total;
   wire push;
   wire in_ready;
   assign wr_lat = {1'b0, i_additive_latency} +
      {1'b0, i_column_write_latency}; // [R3]
   assign total = beats_for(i_burst_mode, bsel_s_q[1]) +
      (i_write_crc ? `SWBT_CRC_BEATS : 4'h0); // [R11]
   // only beats inside the burst window are captured
   assign push = (st_q == ST_DATA) & ck_rise; // [R12]
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         st_q <= ST_IDLE;
         lat_q <= {(LATW+1){1'b0}};
         beat_q <= 4'h0;
         last_q <= 4'h0;
         bg_q <= 1'b0;
         fin_q <= 1'b0;
         o_beat_crc <= 1'b0;
         o_burst_active <= 1'b0;
      end else begin
         fin_q <= 1'b0;
         if (ck_rise) begin
            case (st_q)
               ST_IDLE: begin
                  if (cmd_s_q[1]) begin
                     last_q <= total - 4'h1; // [R5] [R6] [R11]
                     bg_q <= bg_s_q[1];
                     lat_q <= wr_lat - 1'b1;
                     st_q <= (wr_lat <= 1) ? ST_DATA : ST_WAIT; // [R3]
                     o_burst_active <= (wr_lat <= 1);
                     beat_q <= 4'h0;
                  end
               end
               ST_WAIT: begin
                  lat_q <= lat_q - 1'b1;
                  if (lat_q <= 1) begin
                     st_q <= ST_DATA; // [R3]
                     o_burst_active <= 1'b1;
                  end
               end
               ST_DATA: begin
                  beat_q <= beat_q + 4'h1;
                  o_beat_crc <= i_write_crc &
                     (beat_q + 4'h1 + `SWBT_CRC_BEATS > last_q);
                  if (beat_q == last_q) begin
                     st_q <= ST_IDLE;
                     o_burst_active <= 1'b0;
                     o_beat_crc <= 1'b0;
                     fin_q <= 1'b1;
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end
   // ---------------------------------------------------------------
   // recovery and turnaround counters in link clock periods
   // ---------------------------------------------------------------
   reg [TW-1:0] wr_cnt_q;
   reg [TW-1:0] wtrl_cnt_q;
   reg [TW-1:0] wtrs_cnt_q;
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         wr_cnt_q <= {TW{1'b0}};
         wtrl_cnt_q <= {TW{1'b0}};
         wtrs_cnt_q <= {TW{1'b0}};
         o_precharge_ok <= 1'b1;
         o_read_same_ok <= 1'b1;
         o_read_other_ok <= 1'b1;
         o_latency_error <= 1'b0;
      end else begin
         // counting starts at the first edge after the final beat
         if (fin_q) begin
            wr_cnt_q <= i_data_bus_inversion ?
               i_write_recovery_inverted : i_write_recovery_time; // [R4] [R9]
            wtrl_cnt_q <= i_write_to_read_long; // [R7]
            wtrs_cnt_q <= i_write_to_read_short; // [R8]
            o_precharge_ok <= 1'b0;
            o_read_same_ok <= 1'b0;
            o_read_other_ok <= 1'b0;
         end else if (ck_rise) begin
            if (wr_cnt_q != 0) begin
               wr_cnt_q <= wr_cnt_q - 1'b1;
            end
            if (wtrl_cnt_q != 0) begin
               wtrl_cnt_q <= wtrl_cnt_q - 1'b1;
            end
            if (wtrs_cnt_q != 0) begin
               wtrs_cnt_q <= wtrs_cnt_q - 1'b1;
            end
            o_precharge_ok <= (wr_cnt_q <= 1); // [R4] [R1]
            o_read_same_ok <= (wtrl_cnt_q <= 1); // [R7]
            o_read_other_ok <= (wtrs_cnt_q <= 1); // [R8]
         end
         // a new write stalls precharge readiness again; row active time is the
         // controller's own, so it is not tracked here
         if (st_q != ST_IDLE) begin
            o_precharge_ok <= 1'b0; // [R2]
         end
         o_latency_error <= i_preamble_2ck &
            (i_column_write_latency == `SWBT_CWL_FORBIDDEN); // [R10]
      end
   end
   // ---------------------------------------------------------------
   // beat buffer
   // ---------------------------------------------------------------
   // overflow flags a beat lost while the consumer stalled
   assign o_overflow = push & ~in_ready;
   swbt_fifo #(
      .WIDTH(DW),
      .DEPTH(`SWBT_FIFO_DEPTH),
      .AW(3)
   ) u_fifo (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_in_valid(push),
      .o_in_ready(in_ready),
      .i_in_data(dq_s2_q),
      .o_out_valid(o_beat_valid),
      .i_out_ready(i_beat_ready),
      .o_out_data(o_beat_data)
   );
endmodule

/* File: design/swbt_fifo.v */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module swbt_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [WIDTH-1:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   assign o_in_ready = (cnt_q != DEPTH);
   assign o_out_valid = (cnt_q != 0);
   assign o_out_data = mem_q[rd_q];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            mem_q[wr_q] <= i_in_data;
            wr_q <= (wr_q == DEPTH-1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH-1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

/* File: design/swbt_regs.vh */
// constants for the write burst timing block
`ifndef SWBT_REGS_VH
`define SWBT_REGS_VH
// mode register zero burst-mode field encodings
`define SWBT_BM_FIXED8 2'h0
`define SWBT_BM_PERCMD 2'h1
`define SWBT_BM_FIXED4 2'h2
// beats per burst
`define SWBT_BEATS8 4'h8
`define SWBT_BEATS4 4'h4
`define SWBT_CRC_BEATS 4'h2
// default timing counts in link clock periods
`define SWBT_WR_CK 8'h0C
`define SWBT_WR_INV_CK 8'h0E
`define SWBT_WTR_L_CK 8'h09
`define SWBT_WTR_S_CK 8'h03
`define SWBT_FIFO_DEPTH 8
// column write latency refused while the two clock preamble is on
`define SWBT_CWL_FORBIDDEN 6'h09
`endif

/* File: verif/swbt_core_properties.sv */
// port assertions for the write burst timing block
`timescale 1ns/1ps
module swbt_core_chk #(
   parameter DW = 16,
   parameter LATW = 6,
   parameter TW = 8
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_preamble_2ck,
   input wire [LATW-1:0] i_column_write_latency,
   input wire i_write_crc,
   input wire [TW-1:0] i_write_to_read_long,
   input wire [TW-1:0] i_write_to_read_short,
   input wire i_beat_ready,
   input wire o_beat_valid,
   input wire [DW-1:0] o_beat_data,
   input wire o_beat_crc,
   input wire o_burst_active,
   input wire o_precharge_ok,
   input wire o_read_same_ok,
   input wire o_read_other_ok,
   input wire o_latency_error,
   input wire o_overflow
);
   // ------
   // checks
   // ------
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   wire bad_lat = i_preamble_2ck && (i_column_write_latency == 6'h09);
   // recovery is at least one link period, eight ref cycles
   sequence flags_drop; $fell(o_precharge_ok); endsequence
   sequence recovered; ##[1:200] o_precharge_ok; endsequence
   lat_err_set_a: assert property (bad_lat[*3] |-> o_latency_error)
      else $error("latency flag missing");
   lat_err_clr_a: assert property (!bad_lat[*3] |-> !o_latency_error)
      else $error("latency flag spurious");
   crc_beat_a: assert property (o_beat_crc |->
      i_write_crc && o_burst_active)
      else $error("checksum beat without checksum");
   rec_min_a: assert property (flags_drop |=> !o_precharge_ok[*8])
      else $error("recovery too short");
   rec_max_a: assert property (flags_drop |-> recovered)
      else $error("recovery never ends");
   // precharge flag is already held low by the burst itself
   drop_all_a: assert property ($fell(o_read_same_ok) |->
      !o_precharge_ok && !o_read_other_ok) else $error("flag still high");
   short_first_a: assert property ($rose(o_read_same_ok) &&
      i_write_to_read_short <= i_write_to_read_long |-> o_read_other_ok)
      else $error("short turnaround late");
   hold_data_a: assert property (o_beat_valid && !i_beat_ready |=>
      o_beat_valid && $stable(o_beat_data)) else $error("beat not held");
   ovf_full_a: assert property (o_overflow |-> o_beat_valid)
      else $error("overflow with empty buffer");
endmodule
bind swbt_core swbt_core_chk #(.DW(DW), .LATW(LATW), .TW(TW)) u_chk (
   .i_ref_clk, .i_rst, .i_preamble_2ck, .i_column_write_latency,
   .i_write_crc, .i_write_to_read_long, .i_write_to_read_short,
   .i_beat_ready, .o_beat_valid, .o_beat_data, .o_beat_crc, .o_burst_active,
   .o_precharge_ok, .o_read_same_ok, .o_read_other_ok, .o_latency_error,
   .o_overflow);

/* File: verif/swbt_core_tb.sv */
// self-checking bench for the write burst timing block
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module swbt_core_tb;
   reg clk = 1'b0, rst = 1'b1, rdy = 1'b1, crc = 1'b0, inv_en = 1'b0;
   reg pre = 1'b0, bg = 1'b0;
   reg [1:0] mode = 2'h0;
   reg [5:0] add_lat = 6'h01, col_lat = 6'h02;
   wire ck, cmd, bsel, vld, bcrc, act, pok, rsok, rook, lerr, ovf;
   wire [15:0] dq, bdat;
   wire [4:0] fl = {act, bcrc, ~rook, ~rsok, ~pok};
   int errors = 0, tests_run = 0, cyc = 0, povf = 0;
   int lo[5];
   reg [15:0] qd[$];
   // ------
   // harness
   // ------
   always #50 clk = ~clk;
   swbt_ctrl_model m (.o_ck(ck), .o_wr_cmd(cmd), .o_bsel(bsel), .o_dq(dq));
   swbt_core dut (.i_ref_clk(clk), .i_rst(rst), .i_ck(ck), .i_wr_cmd(cmd),
      .i_burst_select_address_bit(bsel), .i_bank_group(bg), .i_dq(dq),
      .i_burst_mode(mode), .i_additive_latency(add_lat),
      .i_column_write_latency(col_lat), .i_data_bus_inversion(inv_en),
      .i_write_crc(crc), .i_preamble_2ck(pre),
      .i_write_recovery_time(8'h05), .i_write_recovery_inverted(8'h07),
      .i_write_to_read_long(8'h04), .i_write_to_read_short(8'h02),
      .o_beat_valid(vld), .i_beat_ready(rdy), .o_beat_data(bdat),
      .o_beat_crc(bcrc), .o_burst_active(act), .o_precharge_ok(pok),
      .o_read_same_ok(rsok), .o_read_other_ok(rook),
      .o_latency_error(lerr), .o_overflow(ovf));
   // run needs about 1000 cycles; ceiling leaves wide margin
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (vld === 1'b1 && rdy) qd.push_back(bdat);
      if (ovf === 1'b1) povf <= povf + 1;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish;
      end
   end
   // link edges seen with each flag low, or checksum beat or window high
   always @(posedge ck) begin
      for (int i = 0; i < 5; i++) lo[i] <= lo[i] + fl[i];
   end
   task automatic tally_and_finish;
      $display("TB: %0d compares, %0d errors", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ------
   // scenarios
   // ------
   task automatic burst(input [1:0] md, input b, c, d, r, input int nd);
      int tot, k;
      tot = nd + (c ? 2 : 0);
      @(posedge clk);
      {mode, crc, inv_en, rdy} <= {md, c, d, r};
      bg <= ~bg;
      qd.delete();
      for (k = 0; k < 5; k++) lo[k] <= 0;
      povf <= 0;
      m.write_burst(b, add_lat + col_lat, tot, 16'h5A00);
      repeat (4) @(posedge clk);
      for (k = 0; k < 300 && !(pok && rsok && rook); k++) @(posedge clk);
      rdy <= 1'b1;
      repeat (20) @(posedge clk);
      `CHK(qd.size(), (r || tot < 8) ? tot : 8)
      for (k = 0; k < qd.size(); k++) `CHK(qd[k], 16'h5A00 + k)
      // precharge is blocked from the write through the recovery count
      `CHK(lo[0], add_lat + col_lat + tot - 1 + (d ? 7 : 5))
      `CHK(lo[4], tot)
      `CHK(lo[1], 4)
      `CHK(lo[2], 2)
      `CHK(lo[3], c ? 2 : 0)
      `CHK(povf, (r || tot < 8) ? 0 : tot - 8)
   endtask
   initial begin
      repeat (8) @(posedge clk);
      `CHK({pok, rsok, rook, act, vld, lerr}, 6'h38)
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      burst(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 8);
      burst(2'h1, 1'b1, 1'b0, 1'b0, 1'b1, 8);
      burst(2'h1, 1'b0, 1'b0, 1'b1, 1'b1, 4);
      burst(2'h2, 1'b1, 1'b1, 1'b0, 1'b1, 4);
      // buffer stalled: ten beats with checksum, eight fill it, two refused, then drains
      burst(2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 8);
      pre <= 1'b1;
      {add_lat, col_lat} <= {6'h00, 6'h09};
      repeat (4) @(posedge clk);
      `CHK(lerr, 1'b1)
      col_lat <= 6'h0A;
      repeat (4) @(posedge clk);
      `CHK(lerr, 1'b0)
      burst(2'h3, 1'b0, 1'b0, 1'b0, 1'b1, 8);
      tally_and_finish;
   end
endmodule

/* File: verif/swbt_ctrl_model.sv */
// controller model: link clock, write command and write data
`timescale 1ns/1ps
module swbt_ctrl_model (
   output reg o_ck = 1'b0,
   output reg o_wr_cmd = 1'b0,
   output reg o_bsel = 1'b0,
   output reg [15:0] o_dq = 16'h0000
);
   // ------
   // driver
   // ------
   // link clock runs free, as a memory clock does
   always #400 o_ck = ~o_ck;
   // caller waits for the ok flags before the next write
   task automatic write_burst(input b, input int lat, input int n,
      input [15:0] base);
      int k;
      @(negedge o_ck);
      o_wr_cmd <= 1'b1;
      o_bsel <= b;
      for (k = 1; k < lat + n; k++) begin
         @(negedge o_ck);
         o_wr_cmd <= 1'b0;
         // outside the window the lines flip, never a stale beat
         o_dq <= (k >= lat) ? 16'(base + k - lat) :
            ~o_dq;
      end
      @(negedge o_ck);
      o_dq <= ~o_dq;
   endtask
endmodule
